/* File: gpa_gpio_ports.sv */
// two quasi-bidirectional ports with serial, interrupt and timer alternate functions
`timescale 1ns/1ps
module gpa_gpio_ports (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  output gpa_pkg::gpa_pad_s port_a_pad,
  output gpa_pkg::gpa_pad_s port_b_pad,
  input wire logic internal_irq,
  input wire logic core_rd_strobe_b,
  input wire logic core_wr_strobe_b,
  output logic first_irq_b,
  output logic dedicated_interrupt_input,
  output logic emu_rd_strobe_b,
  output logic emu_wr_strobe_b,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_i_b;
  // reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_i_b = rst_s2_r;

  logic [7:0] latch_a_r;
  logic [7:0] latch_b_r;
  logic [31:0] ctrl_r;
  logic [31:0] ser_ctrl_r;
  logic [31:0] tmr_ctrl_r;
  logic [7:0] pin_a;
  logic [7:0] pin_b;
  logic [7:0] fall_a;
  logic [7:0] fall_b;
  // synchronise every pad input before use
  for (genvar i = 0; i < 8; i++) begin : g_sync
    gpa_sync2 u_sa (.clk(clk), .rst_b(rst_i_b), .d(port_a_in[i]), .q(pin_a[i]),
      .fall(fall_a[i]));
    gpa_sync2 u_sb (.clk(clk), .rst_b(rst_i_b), .d(port_b_in[i]), .q(pin_b[i]),
      .fall(fall_b[i]));
  end

  // apb decode
  logic acc;
  logic wr;
  logic mapped;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign mapped = (paddr <= gpa_pkg::OFS_STATUS) && (paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  logic wr_a, wr_b, wr_ctrl, wr_ser, wr_serial_buffer_reg, wr_tmr, wr_rld;
  logic serial_buffer_reg_acc;
  assign wr_a = wr & (paddr == gpa_pkg::OFS_PORT_A);
  assign wr_b = wr & (paddr == gpa_pkg::OFS_PORT_B);
  assign wr_ctrl = wr & (paddr == gpa_pkg::OFS_CTRL);
  assign wr_ser = wr & (paddr == gpa_pkg::OFS_SER_CTRL);
  assign wr_serial_buffer_reg = wr & (paddr == gpa_pkg::OFS_SER_BUF);
  assign wr_tmr = wr & (paddr == gpa_pkg::OFS_TMR_CTRL);
  assign wr_rld = wr & (paddr == gpa_pkg::OFS_TMR_C_RLD);
  // software may preset each timer count
  logic [2:0] wr_cnt;
  assign wr_cnt = {wr & (paddr == gpa_pkg::OFS_TMR_C), wr & (paddr == gpa_pkg::OFS_TMR_B),
                   wr & (paddr == gpa_pkg::OFS_TMR_A)};
  assign serial_buffer_reg_acc = acc & (paddr == gpa_pkg::OFS_SER_BUF);

  // software latches and control registers
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      latch_a_r <= gpa_pkg::PORT_RST;
      latch_b_r <= gpa_pkg::PORT_RST;
      ctrl_r <= gpa_pkg::CTRL_RST;
      ser_ctrl_r <= gpa_pkg::CTRL_RST;
      tmr_ctrl_r <= gpa_pkg::CTRL_RST;
    end else begin
      if (wr_a) latch_a_r <= pwdata[7:0];
      if (wr_b) latch_b_r <= pwdata[7:0];
      if (wr_ctrl) ctrl_r <= pwdata;
      if (wr_ser) ser_ctrl_r <= pwdata;
      if (wr_tmr) tmr_ctrl_r <= pwdata;
    end
  end

  // machine-cycle enable: clock divided by 12
  logic [3:0] mdiv_r;
  logic mach_en;
  assign mach_en = (mdiv_r == 4'(gpa_pkg::MACH_DIV - 1));
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) mdiv_r <= 4'h0;
    else mdiv_r <= mach_en ? 4'h0 : mdiv_r + 4'h1;
  end

  // serial unit: simple 10-bit shifter per frame
  gpa_pkg::gpa_ser_mode_e ser_mode;
  logic rx_en;
  assign ser_mode = gpa_pkg::gpa_ser_mode_e'(ser_ctrl_r[gpa_pkg::SER_MODE_LO +: 2]);
  assign rx_en = ser_ctrl_r[gpa_pkg::SER_RX_EN];
  logic [9:0] tx_sh_r;
  logic [3:0] tx_cnt_r;
  logic tx_busy;
  logic sclk_r;
  logic ser_out0;
  logic ser_out1;
  assign tx_busy = (tx_cnt_r != 4'h0);
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      tx_sh_r <= 10'h3FF;
      tx_cnt_r <= 4'h0;
      sclk_r <= 1'b1;
    end else if (serial_buffer_reg_acc && !tx_busy) begin
      // mode 0 sends bare bits; others add start and stop
      tx_sh_r <= (ser_mode == gpa_pkg::GPA_SER_M0) ? {2'b11, pwdata[7:0]}
                                                   : {1'b1, pwdata[7:0], 1'b0};
      tx_cnt_r <= (ser_mode == gpa_pkg::GPA_SER_M0) ? 4'd8 : 4'd10;
    end else if (mach_en && tx_busy) begin
      tx_sh_r <= {1'b1, tx_sh_r[9:1]};
      tx_cnt_r <= tx_cnt_r - 4'h1;
      sclk_r <= 1'b1;
    end else if (tx_busy && mdiv_r == 4'd5) begin
      sclk_r <= 1'b0; // mid-cycle low for clock/12 shift clock
    end
  end
  // idle alternate outputs sit at one
  assign ser_out0 = (ser_mode == gpa_pkg::GPA_SER_M0) ? (tx_busy ? tx_sh_r[0] : 1'b1)
                                                      : 1'b1;
  assign ser_out1 = (ser_mode == gpa_pkg::GPA_SER_M0) ? (tx_busy ? sclk_r : 1'b1)
                                                      : (tx_busy ? tx_sh_r[0] : 1'b1);

  // receiver for modes 1 to 3, one sample per bit time of 12 clocks
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_div_r;
  logic [7:0] rx_sh_r;
  logic rx_start;
  logic rx_tick;
  assign rx_start = rx_en && (ser_mode != gpa_pkg::GPA_SER_M0) && fall_b[0]
                    && (rx_cnt_r == 4'h0);
  // bit timer restarts at each start edge so samples land mid-bit
  assign rx_tick = (rx_div_r == 4'(gpa_pkg::MACH_DIV - 1));
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      rx_cnt_r <= 4'h0;
      rx_div_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_div_r <= rx_tick ? 4'h0 : rx_div_r + 4'h1;
      if (!rx_en) begin
        rx_cnt_r <= 4'h0;
      end else if (rx_start) begin
        rx_cnt_r <= 4'd10;
        rx_div_r <= 4'd6; // first tick falls mid start bit
      end else if (rx_tick && rx_cnt_r != 4'h0) begin
        rx_cnt_r <= rx_cnt_r - 4'h1;
        if (rx_cnt_r == 4'd1) begin
          rx_data <= rx_sh_r;
          rx_valid <= 1'b1;
        end else if (rx_cnt_r != 4'd10) begin
          rx_sh_r <= {pin_b[0], rx_sh_r[7:1]};
        end
      end
    end
  end

  // interrupt and strobe routing
  logic ext_core;
  assign ext_core = ctrl_r[gpa_pkg::CTRL_EXT_CORE];
  assign first_irq_b = pin_b[2] & ~internal_irq;
  assign dedicated_interrupt_input = pin_b[3];
  assign emu_rd_strobe_b = ext_core ? pin_b[7] : 1'b1;
  assign emu_wr_strobe_b = ext_core ? pin_b[6] : 1'b1;

  // port b output: latch ANDed with alternate output
  logic [7:0] alt_b;
  logic [7:0] dout_b;
  assign alt_b = {ext_core ? 1'b1 : core_rd_strobe_b, ext_core ? 1'b1 : core_wr_strobe_b,
                  4'hF, ser_out1, ser_out0};
  assign dout_b = latch_b_r & alt_b;

  // timers a, b, c share one counting scheme
  logic [gpa_pkg::TMR_W-1:0] tmr_r [3];
  logic [gpa_pkg::TMR_W-1:0] cap_r;
  logic [gpa_pkg::TMR_W-1:0] rld_r;
  logic [2:0] ev_fall;
  logic [2:0] run;
  logic trig_c;
  assign ev_fall = {fall_a[0], fall_b[5], fall_b[4]};
  assign trig_c = tmr_ctrl_r[gpa_pkg::TMR_C_TRIG_EN] & fall_a[1];
  for (genvar t = 0; t < 3; t++) begin : g_tmr
    logic cnt_sel;
    logic gate_ok;
    assign cnt_sel = tmr_ctrl_r[4*t + gpa_pkg::TMR_CNT_SEL];
    // only timer b honours its gate pin
    assign gate_ok = (t == 1) ? (~tmr_ctrl_r[4 + gpa_pkg::TMR_GATE] | pin_b[3]) : 1'b1;
    assign run[t] = tmr_ctrl_r[4*t + gpa_pkg::TMR_RUN] & gate_ok &
                    (cnt_sel ? ev_fall[t] : mach_en);
    always_ff @(posedge clk or negedge rst_i_b) begin
      if (!rst_i_b) tmr_r[t] <= '0;
      else if (wr_cnt[t]) tmr_r[t] <= pwdata[gpa_pkg::TMR_W-1:0];
      else if (t == 2 && trig_c && !cnt_sel) tmr_r[t] <= rld_r;
      else if (run[t]) tmr_r[t] <= tmr_r[t] + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      cap_r <= '0;
      rld_r <= '0;
    end else begin
      if (trig_c && tmr_ctrl_r[8 + gpa_pkg::TMR_CNT_SEL]) cap_r <= tmr_r[2];
      if (wr_rld) rld_r <= pwdata[gpa_pkg::TMR_W-1:0];
    end
  end

  // pad drivers
  logic [7:0] dout_a;
  assign dout_a = latch_a_r;
  assign port_a_pad.dout = dout_a;
  assign port_b_pad.dout = dout_b;
  for (genvar i = 0; i < 8; i++) begin : g_pad
    gpa_pad_ctl u_pa (.clk(clk), .rst_b(rst_i_b), .dout(dout_a[i]),
      .pullup_dis(ctrl_r[gpa_pkg::CTRL_PUDIS_A]), .oe_b(port_a_pad.oe_b[i]),
      .pull_en(port_a_pad.pull_en[i]));
    gpa_pad_ctl u_pb (.clk(clk), .rst_b(rst_i_b), .dout(dout_b[i]),
      .pullup_dis(ctrl_r[gpa_pkg::CTRL_PUDIS_B]), .oe_b(port_b_pad.oe_b[i]),
      .pull_en(port_b_pad.pull_en[i]));
  end

  // read mux: pins read their synchronised value
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    case (paddr)
      gpa_pkg::OFS_PORT_A: rmux = {24'h0, pin_a};
      gpa_pkg::OFS_PORT_B: rmux = {24'h0, pin_b};
      gpa_pkg::OFS_CTRL: rmux = ctrl_r;
      gpa_pkg::OFS_SER_CTRL: rmux = ser_ctrl_r;
      gpa_pkg::OFS_SER_BUF: rmux = {24'h0, rx_data};
      gpa_pkg::OFS_TMR_CTRL: rmux = tmr_ctrl_r;
      gpa_pkg::OFS_TMR_A: rmux = {6'h0, tmr_r[0]};
      gpa_pkg::OFS_TMR_B: rmux = {6'h0, tmr_r[1]};
      gpa_pkg::OFS_TMR_C: rmux = {6'h0, tmr_r[2]};
      gpa_pkg::OFS_TMR_C_CAP: rmux = {6'h0, cap_r};
      gpa_pkg::OFS_TMR_C_RLD: rmux = {6'h0, rld_r};
      gpa_pkg::OFS_STATUS: rmux = {22'h0, latch_b_r, tx_busy, rx_cnt_r != 4'h0};
      default: rmux = 32'h0000_0000;
    endcase
  end
  assign prdata = rmux;
endmodule

/* File: gpa_gpio_properties.sv */
// concurrent checks on the pins of the gpio port block
`timescale 1ns/1ps
module gpa_gpio_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic [7:0] port_b_in,
  input wire gpa_pkg::gpa_pad_s port_a_pad,
  input wire gpa_pkg::gpa_pad_s port_b_pad,
  input wire logic internal_irq,
  input wire logic first_irq_b,
  input wire logic dedicated_interrupt_input,
  input wire logic emu_rd_strobe_b,
  input wire logic emu_wr_strobe_b
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // a rising output keeps its driver on for two more clocks
  chk_drive_port_a: assert property (
    port_a_pad.oe_b == (port_a_pad.dout & $past(port_a_pad.dout, 2)))
    else $error("port a driver enable wrong");
  chk_drive_port_b: assert property (
    port_b_pad.oe_b == (port_b_pad.dout & $past(port_b_pad.dout, 2)))
    else $error("port b driver enable wrong");
  // leaving reset every pin is an input with its pull-up on
  chk_reset_idle: assert property ($rose(rst_b) |->
    (port_a_pad.oe_b & port_b_pad.oe_b & port_a_pad.pull_en & port_b_pad.pull_en) == 8'hFF)
    else $error("pins not idle after reset");
  // first interrupt input merges internal sources and pin 2
  chk_irq_internal: assert property (internal_irq |-> !first_irq_b)
    else $error("internal interrupt not passed on");
  chk_irq_pin: assert property ($fell(port_b_in[2]) |-> ##2 !first_irq_b)
    else $error("pin interrupt not passed on");
  chk_second_irq: assert property ($changed(port_b_in[3]) |->
    ##2 dedicated_interrupt_input == $past(port_b_in[3], 2))
    else $error("second interrupt does not follow pin 3");
  // emulator strobes only come from their pins
  chk_emu_read: assert property (!emu_rd_strobe_b |-> !$past(port_b_in[7], 2))
    else $error("read strobe without pin");
  chk_emu_write: assert property (!emu_wr_strobe_b |-> !$past(port_b_in[6], 2))
    else $error("write strobe without pin");
  chk_bad_addr: assert property (psel && penable && paddr > 8'h2C |-> pslverr)
    else $error("unmapped access not refused");
  cover property ($rose(port_a_pad.oe_b[0]));
  cover property (!first_irq_b && !internal_irq);
  cover property (!emu_rd_strobe_b && !emu_wr_strobe_b);
endmodule

/* File: gpa_pad_ctl.sv */
// one pad bit: two-clock active high drive, then pull-up or float
`timescale 1ns/1ps
module gpa_pad_ctl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic dout,
  input wire logic pullup_dis,
  output logic oe_b,
  output logic pull_en
);
  logic d1_r;
  logic d2_r;
  // two-clock delayed copy of the output bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d1_r <= 1'b1;
      d2_r <= 1'b1;
    end else begin
      d1_r <= dout;
      d2_r <= d1_r;
    end
  end
  assign oe_b = dout & d2_r;
  assign pull_en = ~pullup_dis;
endmodule

/* File: gpa_pin_model.sv */
// external devices on one port: open-drain sinks beside the pad's pull-up
`timescale 1ns/1ps
module gpa_pin_model (
  input wire logic clk,
  input wire gpa_pkg::gpa_pad_s pad,
  input wire logic [7:0] ext_low,
  output logic [7:0] pin
);
  logic [7:0] float_r = 8'h00;
  // a line nobody drives or pulls shows a changing pattern, not a held level
  always_ff @(posedge clk) float_r <= ~float_r;
  // pad driver wins, then an external sink, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad.oe_b[i]) pin[i] = pad.dout[i];
      else if (ext_low[i]) pin[i] = 1'b0;
      else if (pad.pull_en[i]) pin[i] = 1'b1;
      else pin[i] = float_r[i];
    end
  end
endmodule

/* File: gpa_pkg.sv */
// package: register map, field layout, reset values and timing counts for the gpio port block
// Behaviour
// - each pad merges input and output into one line; active-low driver enable
// - driver enable is output bit ANDed with its two-clock delayed copy
// - per-port pull-up disable makes a released high float after two clocks
// - after reset all pins are inputs with pull-ups enabled
// - port b alternate inputs come from the synchronised pin, the same value software reads
// - port b output is latch ANDed with alternate output; idle alternate is one
// - serial mode 0 sends data on bit 0 and clock/12 on bit 1
// - serial modes 1 to 3 receive on bit 0, transmit on bit 1, full duplex
// - serial buffer access starts transmission; otherwise serial outputs stay one
// - reception only while receive enable is one
// - port b bit 2 feeds first interrupt input, ORed with internal interrupts
// - second interrupt input comes only from port b bit 3, also timer b gate
// - timers count per machine cycle (clock/12) or on event pin falling edge
// - only the second timer may be gated externally
// - third timer trigger on port a bit 1 captures in counter, reloads in timer mode
// - external core mode: port b bits 7 and 6 take emulator read/write strobes
// - port a has alternate inputs only on bits 0 and 1, no alternate outputs
package gpa_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_PORT_A = 8'h00;
  localparam logic [7:0] OFS_PORT_B = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_SER_CTRL = 8'h0C;
  localparam logic [7:0] OFS_SER_BUF = 8'h10;
  localparam logic [7:0] OFS_TMR_CTRL = 8'h14;
  localparam logic [7:0] OFS_TMR_A = 8'h18;
  localparam logic [7:0] OFS_TMR_B = 8'h1C;
  localparam logic [7:0] OFS_TMR_C = 8'h20;
  localparam logic [7:0] OFS_TMR_C_CAP = 8'h24;
  localparam logic [7:0] OFS_TMR_C_RLD = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  // control register fields
  localparam int CTRL_PUDIS_A = 0;
  localparam int CTRL_PUDIS_B = 1;
  localparam int CTRL_EXT_CORE = 2;
  localparam int CTRL_EXTERNAL_INTERRUPT_PIN_EN = 3;
  // serial control fields
  localparam int SER_RX_EN = 0;
  localparam int SER_MODE_LO = 1;
  // timer control fields, one nibble per timer: run, counter select, gate, irq enable
  localparam int TMR_RUN = 0;
  localparam int TMR_CNT_SEL = 1;
  localparam int TMR_GATE = 2;
  localparam int TMR_IE = 3;
  localparam int TMR_C_TRIG_EN = 12;
  // reset values
  localparam logic [7:0] PORT_RST = 8'hFF;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int DRIVE_HOLD_CYC = 2;
  localparam int MACH_DIV = 12;
  localparam int TMR_W = 26;
  typedef enum logic [1:0] {
    GPA_SER_M0 = 2'd0,
    GPA_SER_M1 = 2'd1,
    GPA_SER_M2 = 2'd2,
    GPA_SER_M3 = 2'd3
  } gpa_ser_mode_e;
  // pad bundle for one 8-bit port
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_b;
    logic [7:0] pull_en;
  } gpa_pad_s;
endpackage

/* File: gpa_sync2.sv */
// two-flop synchroniser plus falling-edge detect for one bit
`timescale 1ns/1ps
module gpa_sync2 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic d,
  output logic q,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // first flop feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign q = s2_r;
  assign fall = s3_r & ~s2_r;
endmodule

/* File: tb_top.sv */
// self-checking bench for the two gpio ports
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module tb_top;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, internal_irq = 0;
  logic core_rd_strobe_b = 1, core_wr_strobe_b = 1, err;
  logic [7:0] paddr = 8'h00, ext_a = 8'h00, ext_b = 8'h00, port_a_in, port_b_in, rx_data;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, first_irq_b, dedicated_interrupt_input, rx_valid;
  logic emu_rd_strobe_b, emu_wr_strobe_b;
  gpa_pkg::gpa_pad_s port_a_pad, port_b_pad;
  int miscompares = 0, checks = 0, cyc = 0, na, nb, nrx = 0;
  // count received-byte pulses
  always @(posedge clk) if (rx_valid === 1'b1) nrx++;
  always #2.5 clk = ~clk;
  gpa_gpio_ports DUT (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .port_a_in, .port_b_in, .port_a_pad, .port_b_pad, .internal_irq,
    .core_rd_strobe_b, .core_wr_strobe_b, .first_irq_b, .dedicated_interrupt_input,
    .emu_rd_strobe_b, .emu_wr_strobe_b, .rx_data, .rx_valid);
  gpa_pin_model PA (.clk, .pad(port_a_pad), .ext_low(ext_a), .pin(port_a_in));
  gpa_pin_model PB (.clk, .pad(port_b_pad), .ext_low(ext_b), .pin(port_b_in));
  task stop_test;
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test;
    end
  end
  // one apb transfer: setup, then access until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one serial frame into port b bit 0, lsb first, 12 clocks a bit
  task send_rx(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      ext_b <= {7'h00, ~f[i]};
      tick(12);
    end
    tick(20);
  endtask
  // count settled cycles until shift clock pin reaches level v
  task wait_b1(input logic v, output int n);
    n = 0;
    while (port_b_pad.dout[1] !== v && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  initial begin
    tick(8);
    rst_b <= 1'b1;
    tick(3);
    #1 `CHK("a_oe_b", 8'hFF, port_a_pad.oe_b)
    `CHK("b_pull", 8'hFF, port_b_pad.pull_en)
    `CHK("b_dout", 8'hFF, port_b_pad.dout)
    apb(1, gpa_pkg::OFS_PORT_A, 32'h0000_0000);
    #1 `CHK("a_low_drive", 8'h00, port_a_pad.oe_b)
    apb(1, gpa_pkg::OFS_PORT_A, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      #1 `CHK("a0_rise_oe_b", (i == 2), port_a_pad.oe_b[0])
      @(posedge clk);
    end
    apb(1, gpa_pkg::OFS_CTRL, 32'h0000_0001);
    tick(3);
    #1 `CHK("a0_pull", 1'b0, port_a_pad.pull_en[0])
    `CHK("a0_float", 1'b1, port_a_pad.oe_b[0])
    `CHK("b_pull_kept", 8'hFF, port_b_pad.pull_en)
    apb(1, gpa_pkg::OFS_CTRL, 32'h0000_0000);
    ext_b <= 8'h28;
    tick(4);
    apb(0, gpa_pkg::OFS_PORT_B, 32'h0000_0000);
    `CHK("b_pins", 8'hD7, rd[7:0])
    `CHK("second_irq_low", 1'b0, dedicated_interrupt_input)
    ext_b <= 8'h04;
    tick(4);
    #1 `CHK("first_irq_pin", 1'b0, first_irq_b)
    `CHK("second_irq_high", 1'b1, dedicated_interrupt_input)
    tick(1);
    ext_b <= 8'h00;
    internal_irq <= 1'b1;
    tick(4);
    #1 `CHK("first_irq_int", 1'b0, first_irq_b)
    tick(1);
    internal_irq <= 1'b0;
    tick(4);
    #1 `CHK("first_irq_idle", 1'b1, first_irq_b)
    apb(1, gpa_pkg::OFS_CTRL, 32'h0000_0004);
    ext_b <= 8'hC0;
    tick(4);
    #1 `CHK("emu_in", 2'b00, {emu_rd_strobe_b, emu_wr_strobe_b})
    apb(1, gpa_pkg::OFS_CTRL, 32'h0000_0000);
    tick(4);
    #1 `CHK("emu_off", 2'b11, {emu_rd_strobe_b, emu_wr_strobe_b})
    tick(1);
    ext_b <= 8'h00;
    core_rd_strobe_b <= 1'b0;
    tick(4);
    #1 `CHK("core_rd_out", 1'b0, port_b_pad.dout[7])
    tick(1);
    core_rd_strobe_b <= 1'b1;
    apb(1, gpa_pkg::OFS_TMR_CTRL, 32'h0000_0001);
    tick(120);
    apb(0, gpa_pkg::OFS_TMR_A, 32'h0000_0000);
    `CHK("tmr_a_cycles", 1'b1, (rd >= 9 && rd <= 11))
    apb(1, gpa_pkg::OFS_TMR_CTRL, 32'h0000_0000);
    apb(1, gpa_pkg::OFS_TMR_A, 32'h0000_0000);
    apb(1, gpa_pkg::OFS_TMR_CTRL, 32'h0000_0003);
    for (int i = 0; i < 5; i++) begin
      ext_b <= 8'h10;
      tick(13);
      ext_b <= 8'h00;
      tick(13);
    end
    apb(0, gpa_pkg::OFS_TMR_A, 32'h0000_0000);
    `CHK("tmr_a_events", 32'h0000_0005, rd)
    apb(1, gpa_pkg::OFS_SER_CTRL, 32'h0000_0000);
    apb(1, gpa_pkg::OFS_SER_BUF, 32'h0000_00A5);
    wait_b1(1'b0, na);
    wait_b1(1'b1, na);
    wait_b1(1'b0, nb);
    `CHK("shift_clk_period", 12, na + nb)
    apb(0, 8'h30, 32'h0000_0000);
    `CHK("bad_addr_err", 1'b1, err)
    `CHK("bad_addr_data", 32'h0000_0000, rd)
    tick(100);
    apb(1, gpa_pkg::OFS_SER_CTRL, 32'h0000_0003);
    send_rx(8'h5A);
    `CHK("rx_byte", 8'h5A, rx_data)
    `CHK("rx_frames", 1, nrx)
    apb(1, gpa_pkg::OFS_SER_CTRL, 32'h0000_0002);
    send_rx(8'hC3);
    `CHK("rx_off", 1, nrx)
    stop_test;
  end
endmodule
bind gpa_gpio_ports gpa_gpio_properties u_props (.clk, .rst_b, .psel, .penable, .paddr,
  .pslverr, .port_b_in, .port_a_pad, .port_b_pad, .internal_irq, .first_irq_b,
  .dedicated_interrupt_input, .emu_rd_strobe_b, .emu_wr_strobe_b);
